// ===== rtl/pwm_pkg.sv
// Constants and types shared by the timer based PWM block
package pwm_pkg;

    // ------------------------------------------------------------
    // Bus geometry
    // ------------------------------------------------------------
    localparam int unsigned ADDR_W    = 8;
    localparam int unsigned DATA_W    = 32;
    localparam int unsigned BE_W      = 4;
    localparam int unsigned NUM_UNITS = 2;

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_TB_COUNT     = 8'h00;
    localparam logic [7:0] OFS_TB_PERIOD    = 8'h04;
    localparam logic [7:0] OFS_TB_CONTROL   = 8'h08;
    localparam logic [7:0] OFS_U1_DUTY_LOW  = 8'h0C;
    localparam logic [7:0] OFS_U1_DUTY_SHAD = 8'h10;
    localparam logic [7:0] OFS_U1_CONTROL   = 8'h14;
    localparam logic [7:0] OFS_U2_DUTY_LOW  = 8'h18;
    localparam logic [7:0] OFS_U2_DUTY_SHAD = 8'h1C;
    localparam logic [7:0] OFS_U2_CONTROL   = 8'h20;
    localparam logic [7:0] OFS_SHUTDOWN_CFG = 8'h24;
    localparam logic [7:0] OFS_DEADBAND_DLY = 8'h28;
    localparam logic [7:0] UNIT_STRIDE      = 8'h0C;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RST_BYTE  = 8'h00;
    localparam logic [1:0] RST_LSB   = 2'h0;
    localparam logic [5:0] RST_FINE  = 6'h00;
    localparam logic [3:0] RST_POST  = 4'h0;

    // ------------------------------------------------------------
    // Timing: oscillator periods per timebase increment
    // ------------------------------------------------------------
    localparam int unsigned OSC_PER_INC = 4;
    localparam logic [5:0]  FINE_LAST_DIV1  = 6'(OSC_PER_INC * 1 - 1);
    localparam logic [5:0]  FINE_LAST_DIV4  = 6'(OSC_PER_INC * 4 - 1);
    localparam logic [5:0]  FINE_LAST_DIV16 = 6'(OSC_PER_INC * 16 - 1);

    // ------------------------------------------------------------
    // Field encodings
    // ------------------------------------------------------------
    localparam logic [1:0] PRESC_DIV1 = 2'h0;
    localparam logic [1:0] PRESC_DIV4 = 2'h1;
    localparam logic [3:0] MODE_OFF   = 4'h0;
    localparam logic [1:0] MODE_PWM   = 2'h3;

    typedef struct packed {
        logic       reserved;
        logic [3:0] postscale_sel;
        logic       run;
        logic [1:0] prescale_sel;
    } tb_ctrl_t;

    typedef struct packed {
        logic [1:0] output_cfg;
        logic [1:0] duty_lsb_bits;
        logic [3:0] mode_select;
    } unit_ctrl_t;

endpackage : pwm_pkg

// ===== rtl/timer_based_pwm_output.sv
// Timer based PWM output block with timebase, two PWM units and Avalon-MM slave
// Notes on behaviour
// - Period is (period register + 1) times four oscillator periods times prescale.
// - Counter equal to period clears to zero on the next increment.
// - Output goes high at each period start unless duty is zero.
// - Duty low byte copies into shadow register at each period start.
// - Postscaler only divides the period event, never changes the period.
// - Duty is ten bits: low register on top, control bits 5:4 below.
// - High time equals duty times one oscillator period times prescale.
// - Duty writes any time; new duty applies only after period match.
// - Shadow duty register is read only while in PWM mode.
// - Shadow byte plus hidden two-bit latch double-buffer the duty.
// - Output clears when buffered duty matches counter extended by two bits.
// - Duty longer than period never matches; output stays high all period.
// - Second unit has no shutdown; only first unit holds shutdown config.
// - Prescaler divides by one, four or sixteen per prescale field.
// - Writing zero to unit control forces the output latch low.
// - Mode upper bits both set selects PWM; all zero turns unit off.
module timer_based_pwm_output (
    input  wire logic                          CORE_CLK,
    input  wire logic                          SYS_RST,
    input  wire logic [pwm_pkg::ADDR_W-1:0]    AVS_ADDRESS,
    input  wire logic                          AVS_READ,
    input  wire logic                          AVS_WRITE,
    input  wire logic [pwm_pkg::DATA_W-1:0]    AVS_WRITEDATA,
    input  wire logic [pwm_pkg::BE_W-1:0]      AVS_BYTEENABLE,
    output logic      [pwm_pkg::DATA_W-1:0]    AVS_READDATA,
    output logic                               AVS_WAITREQUEST,
    output logic      [pwm_pkg::NUM_UNITS-1:0] PWM_OUT,
    output logic                               TIMEBASE_EVENT
);
    import pwm_pkg::*;

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic                  waitrequest_r;
    logic [DATA_W-1:0]     readdata_r;
    logic [DATA_W-1:0]     readdata_nxt;
    logic                  bus_wr;
    logic [7:0]            wr_byte;

    logic [7:0]            count_r;
    logic [7:0]            count_nxt;
    logic [7:0]            period_r;
    tb_ctrl_t              tb_ctrl_r;
    logic [5:0]            fine_r;
    logic [5:0]            fine_nxt;
    logic [5:0]            fine_last;
    logic                  inc_tick;
    logic                  boundary;
    logic [1:0]            sub_nxt;
    logic [9:0]            ext_nxt;
    logic [3:0]            post_cnt_r;
    logic                  event_r;

    logic [7:0]            shutdown_cfg_r;
    logic [7:0]            deadband_r;

    logic [7:0]            duty_low_r   [NUM_UNITS];
    logic [7:0]            duty_shad_r  [NUM_UNITS];
    logic [1:0]            lsb_latch_r  [NUM_UNITS];
    unit_ctrl_t            unit_ctrl_r  [NUM_UNITS];
    logic [NUM_UNITS-1:0]  out_r;

    // ------------------------------------------------------------
    // Avalon-MM slave handshake
    // ------------------------------------------------------------
    // One wait state: request seen, then answered on the next edge
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            waitrequest_r <= 1'b1;
        end else if (waitrequest_r && (AVS_READ || AVS_WRITE)) begin
            waitrequest_r <= 1'b0;
        end else begin
            waitrequest_r <= 1'b1;
        end
    end

    assign bus_wr  = AVS_WRITE && !waitrequest_r && AVS_BYTEENABLE[0];
    assign wr_byte = AVS_WRITEDATA[7:0];

    always_comb begin
        readdata_nxt = '0;
        unique case (AVS_ADDRESS)
            OFS_TB_COUNT:     readdata_nxt[7:0] = count_r;
            OFS_TB_PERIOD:    readdata_nxt[7:0] = period_r;
            OFS_TB_CONTROL:   readdata_nxt[7:0] = {1'b0, tb_ctrl_r[6:0]};
            OFS_U1_DUTY_LOW:  readdata_nxt[7:0] = duty_low_r[0];
            OFS_U1_DUTY_SHAD: readdata_nxt[7:0] = duty_shad_r[0];
            OFS_U1_CONTROL:   readdata_nxt[7:0] = unit_ctrl_r[0];
            OFS_U2_DUTY_LOW:  readdata_nxt[7:0] = duty_low_r[1];
            OFS_U2_DUTY_SHAD: readdata_nxt[7:0] = duty_shad_r[1];
            OFS_U2_CONTROL:   readdata_nxt[7:0] = {2'b00, unit_ctrl_r[1][5:0]};
            OFS_SHUTDOWN_CFG: readdata_nxt[7:0] = shutdown_cfg_r;
            OFS_DEADBAND_DLY: readdata_nxt[7:0] = deadband_r;
            default:          readdata_nxt      = '0;
        endcase
    end

    // Read data captured with the request, valid while waitrequest is low
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            readdata_r <= '0;
        end else if (waitrequest_r && AVS_READ) begin
            readdata_r <= readdata_nxt;
        end
    end

    // ------------------------------------------------------------
    // Timebase prescaler and counter
    // ------------------------------------------------------------
    // prescale select
    always_comb begin
        unique case (tb_ctrl_r.prescale_sel)
            PRESC_DIV1: fine_last = FINE_LAST_DIV1;
            PRESC_DIV4: fine_last = FINE_LAST_DIV4;
            default:    fine_last = FINE_LAST_DIV16;
        endcase
    end

    // increment every four oscillator periods times prescale
    assign inc_tick = tb_ctrl_r.run && (fine_r >= fine_last);
    assign boundary = inc_tick && (count_r == period_r);

    always_comb begin
        fine_nxt  = fine_r;
        count_nxt = count_r;
        if (bus_wr && AVS_ADDRESS == OFS_TB_COUNT) begin
            fine_nxt  = RST_FINE;
            count_nxt = wr_byte;
        end else if (tb_ctrl_r.run) begin
            if (inc_tick) begin
                fine_nxt = RST_FINE;
                if (boundary) begin
                    count_nxt = RST_BYTE;
                end else begin
                    count_nxt = 8'(count_r + 8'h01);
                end
            end else begin
                fine_nxt = 6'(fine_r + 6'h01);
            end
        end
    end

    // two extra low bits from the quarter phase or prescaler
    always_comb begin
        unique case (tb_ctrl_r.prescale_sel)
            PRESC_DIV1: sub_nxt = fine_nxt[1:0];
            PRESC_DIV4: sub_nxt = fine_nxt[3:2];
            default:    sub_nxt = fine_nxt[5:4];
        endcase
    end

    assign ext_nxt = {count_nxt, sub_nxt};

    // counter and prescaler clear at reset
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            fine_r  <= RST_FINE;
            count_r <= RST_BYTE;
        end else begin
            fine_r  <= fine_nxt;
            count_r <= count_nxt;
        end
    end

    // ------------------------------------------------------------
    // Postscaler on the period event
    // ------------------------------------------------------------
    // divides the period event only, period untouched
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            post_cnt_r <= RST_POST;
            event_r    <= 1'b0;
        end else if (boundary) begin
            if (post_cnt_r == tb_ctrl_r.postscale_sel) begin
                post_cnt_r <= RST_POST;
                event_r    <= 1'b1;
            end else begin
                post_cnt_r <= 4'(post_cnt_r + 4'h1);
                event_r    <= 1'b0;
            end
        end else begin
            event_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Timebase and shared configuration registers
    // ------------------------------------------------------------
    // period and controls clear at reset
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            period_r  <= RST_BYTE;
            tb_ctrl_r <= tb_ctrl_t'(RST_BYTE);
        end else if (bus_wr) begin
            if (AVS_ADDRESS == OFS_TB_PERIOD) begin
                period_r <= wr_byte;
            end
            if (AVS_ADDRESS == OFS_TB_CONTROL) begin
                tb_ctrl_r <= tb_ctrl_t'({1'b0, wr_byte[6:0]});
            end
        end
    end

    // shutdown and dead band settings belong to the first unit only
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            shutdown_cfg_r <= RST_BYTE;
            deadband_r     <= RST_BYTE;
        end else if (bus_wr) begin
            if (AVS_ADDRESS == OFS_SHUTDOWN_CFG) begin
                shutdown_cfg_r <= wr_byte;
            end
            if (AVS_ADDRESS == OFS_DEADBAND_DLY) begin
                deadband_r <= wr_byte;
            end
        end
    end

    // ------------------------------------------------------------
    // PWM units
    // ------------------------------------------------------------
    for (genvar u = 0; u < NUM_UNITS; u++) begin : g_unit
        localparam logic [7:0] BASE = 8'(OFS_U1_DUTY_LOW + 8'(u) * UNIT_STRIDE);

        logic       pwm_on;
        logic       unit_off;
        logic [9:0] duty_new;
        logic       wr_low;
        logic       wr_shad;
        logic       wr_ctrl;

        // both upper mode bits select PWM, zero turns it off
        assign pwm_on   = unit_ctrl_r[u].mode_select[3:2] == MODE_PWM;
        assign unit_off = unit_ctrl_r[u].mode_select == MODE_OFF;
        // ten-bit duty, low register above the two control bits
        assign duty_new = {duty_low_r[u], unit_ctrl_r[u].duty_lsb_bits};
        assign wr_low   = bus_wr && AVS_ADDRESS == BASE;
        assign wr_shad  = bus_wr && AVS_ADDRESS == 8'(BASE + 8'h04);
        assign wr_ctrl  = bus_wr && AVS_ADDRESS == 8'(BASE + 8'h08);

        // software may rewrite duty at any moment
        always_ff @(posedge CORE_CLK) begin
            if (SYS_RST) begin
                duty_low_r[u] <= RST_BYTE;
            end else if (wr_low) begin
                duty_low_r[u] <= wr_byte;
            end
        end

        // second unit keeps its upper control bits at zero
        always_ff @(posedge CORE_CLK) begin
            if (SYS_RST) begin
                unit_ctrl_r[u] <= unit_ctrl_t'(RST_BYTE);
            end else if (wr_ctrl) begin
                unit_ctrl_r[u] <= unit_ctrl_t'((u == 0) ? wr_byte : {2'b00, wr_byte[5:0]});
            end
        end

        // shadow byte and hidden latch hold the active duty
        always_ff @(posedge CORE_CLK) begin
            if (SYS_RST) begin
                duty_shad_r[u] <= RST_BYTE;
                lsb_latch_r[u] <= RST_LSB;
            end else if (pwm_on) begin
                // copy duty into the shadow at period start
                if (boundary) begin
                    duty_shad_r[u] <= duty_low_r[u];
                    lsb_latch_r[u] <= unit_ctrl_r[u].duty_lsb_bits;
                end
            end else begin
                // shadow writes only taken outside PWM mode
                if (wr_shad) begin
                    duty_shad_r[u] <= wr_byte;
                end
                if (unit_off) begin
                    lsb_latch_r[u] <= RST_LSB;
                end
            end
        end

        // Output latch
        always_ff @(posedge CORE_CLK) begin
            if (SYS_RST) begin
                out_r[u] <= 1'b0;
            end else if (!pwm_on) begin
                // unit off or non-PWM mode holds the latch low
                out_r[u] <= 1'b0;
            end else if (boundary) begin
                // set at period start, not for zero duty
                out_r[u] <= (duty_new != 10'h000);
            end else if (ext_nxt == {duty_shad_r[u], lsb_latch_r[u]}) begin
                // high time duty times prescaled oscillator period
                // no match inside the period keeps it high
                out_r[u] <= 1'b0;
            end
        end
    end : g_unit

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign AVS_WAITREQUEST = waitrequest_r;
    assign AVS_READDATA    = readdata_r;
    assign PWM_OUT         = out_r;
    assign TIMEBASE_EVENT  = event_r;

endmodule // timer_based_pwm_output

// ===== testbench/timer_based_pwm_output_sva.sv
// Port level checker for the timer based PWM block
module timer_based_pwm_output_sva
    import pwm_pkg::*;
(
    input wire logic                          CORE_CLK,
    input wire logic                          SYS_RST,
    input wire logic [pwm_pkg::ADDR_W-1:0]    AVS_ADDRESS,
    input wire logic                          AVS_READ,
    input wire logic                          AVS_WRITE,
    input wire logic [pwm_pkg::DATA_W-1:0]    AVS_WRITEDATA,
    input wire logic [pwm_pkg::BE_W-1:0]      AVS_BYTEENABLE,
    input wire logic [pwm_pkg::DATA_W-1:0]    AVS_READDATA,
    input wire logic                          AVS_WAITREQUEST,
    input wire logic [pwm_pkg::NUM_UNITS-1:0] PWM_OUT,
    input wire logic                          TIMEBASE_EVENT
);
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (SYS_RST);

    chk_wait_one: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
        else $error("waitrequest not released one cycle after request");
    chk_wait_pulse: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
        else $error("waitrequest low longer than one cycle");
    chk_no_spurious: assert property (!AVS_READ && !AVS_WRITE && AVS_WAITREQUEST |=> AVS_WAITREQUEST)
        else $error("waitrequest dropped without request");
    chk_read_upper: assert property (!AVS_WAITREQUEST |-> AVS_READDATA[31:8] == 24'h000000)
        else $error("read data upper bits not zero");
    chk_rdata_hold: assert property (!(AVS_READ && AVS_WAITREQUEST) |=> $stable(AVS_READDATA))
        else $error("read data changed without a read");
    chk_quiet_reset: assert property ($fell(SYS_RST) |-> PWM_OUT == 2'h0 && !TIMEBASE_EVENT)
        else $error("outputs active right after reset");
    chk_event_gap: assert property (TIMEBASE_EVENT |=> !TIMEBASE_EVENT [*3])
        else $error("period events closer than four clocks");
    chk_off_clear: assert property (AVS_WRITE && !AVS_WAITREQUEST && AVS_BYTEENABLE[0]
        && AVS_ADDRESS == OFS_U1_CONTROL && AVS_WRITEDATA[7:0] == 8'h00 |-> ##2 !PWM_OUT[0] [*2])
        else $error("output not low after control cleared");
endmodule // timer_based_pwm_output_sva

bind timer_based_pwm_output timer_based_pwm_output_sva u_timer_based_pwm_output_sva (
    .CORE_CLK(CORE_CLK), .SYS_RST(SYS_RST), .AVS_ADDRESS(AVS_ADDRESS),
    .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA),
    .AVS_BYTEENABLE(AVS_BYTEENABLE), .AVS_READDATA(AVS_READDATA),
    .AVS_WAITREQUEST(AVS_WAITREQUEST), .PWM_OUT(PWM_OUT), .TIMEBASE_EVENT(TIMEBASE_EVENT)
);

// ===== testbench/pwm_load.sv
// Load model that measures high time and period of the pulse pin
module pwm_load (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        pin,
    output logic            meas_valid,
    output logic [15:0]     high_cnt,
    output logic [15:0]     per_cnt
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] h_r;
    logic [15:0] p_r;
    logic        pin_r;
    logic        armed_r;

    // Report the last full period at each rising edge
    always_ff @(posedge clk) begin
        if (rst) begin
            {h_r, p_r, pin_r, armed_r, meas_valid, high_cnt, per_cnt} <= '0;
        end else begin
            pin_r      <= pin;
            meas_valid <= 1'b0;
            if (pin === 1'b1 && pin_r === 1'b0) begin
                meas_valid <= armed_r;
                high_cnt   <= h_r;
                per_cnt    <= p_r;
                armed_r    <= 1'b1;
                h_r        <= 16'h0001;
                p_r        <= 16'h0001;
            end else begin
                h_r <= h_r + 16'(pin === 1'b1);
                p_r <= p_r + 16'h0001;
            end
        end
    end
endmodule // pwm_load

// ===== testbench/tb_timer_based_pwm_output.sv
// Self-checking bench for the timer based PWM block
module tb_timer_based_pwm_output;
    import pwm_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic        core_clk      = 1'b0;
    logic        sys_rst       = 1'b1;
    logic [7:0]  avs_address   = 8'h00;
    logic        avs_read      = 1'b0;
    logic        avs_write     = 1'b0;
    logic [31:0] avs_writedata = 32'h00000000;
    logic [3:0]  be_r          = 4'hF;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic [1:0]  pwm_out;
    logic        tb_event;
    logic        meas_valid;
    logic [15:0] high_cnt;
    logic [15:0] per_cnt;
    logic [31:0] rd_q[$];
    logic [31:0] ms_q[$];
    int          fails = 0;
    int          n_checks = 0;
    int          cyc = 0;
    int          seed;

    timer_based_pwm_output u_timer_based_pwm_output (
        .CORE_CLK(core_clk), .SYS_RST(sys_rst), .AVS_ADDRESS(avs_address),
        .AVS_READ(avs_read), .AVS_WRITE(avs_write), .AVS_WRITEDATA(avs_writedata),
        .AVS_BYTEENABLE(be_r), .AVS_READDATA(avs_readdata), .AVS_WAITREQUEST(avs_waitrequest),
        .PWM_OUT(pwm_out), .TIMEBASE_EVENT(tb_event));
    pwm_load u_pwm_load (.clk(core_clk), .rst(sys_rst), .pin(pwm_out[0]),
        .meas_valid(meas_valid), .high_cnt(high_cnt), .per_cnt(per_cnt));

    always #5 core_clk = ~core_clk;

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic complete_run;
        if (fails == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        avs_address   <= a;
        avs_write     <= wr;
        avs_read      <= !wr;
        avs_writedata <= {24'h000000, d};
        do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        rd_q.push_back({24'h000000, e});
        bus(1'b0, a, 8'h00);
    endtask

    // Skip two transitional periods, then check the next one
    task automatic meas(input int h, input int p);
        repeat (2) begin
            do @(posedge core_clk); while (meas_valid !== 1'b1);
        end
        #1 ms_q.push_back({16'(h), 16'(p)});
        wait (ms_q.size() == 0);
        @(posedge core_clk);
    endtask

    task automatic sample(input int len, input int exp);
        int cnt;
        cnt = 0;
        repeat (3 * len) @(posedge core_clk);
        repeat (len) begin
            @(posedge core_clk);
            cnt += int'(pwm_out[0] === 1'b1);
        end
        chk(32'(cnt), 32'(exp));
    endtask

    // Count period events after the postscaler has settled
    task automatic ev_cnt(input int len, input int exp);
        int cnt;
        cnt = 0;
        repeat (3 * len) @(posedge core_clk);
        repeat (len) begin
            @(posedge core_clk);
            cnt += int'(tb_event === 1'b1);
        end
        chk(32'(cnt), 32'(exp));
    endtask

    // ------------------------------------------------------------
    // Result watcher and timeout
    // ------------------------------------------------------------
    always @(posedge core_clk) begin
        cyc++;
        if (avs_read && avs_waitrequest === 1'b0 && rd_q.size() > 0)
            chk(avs_readdata, rd_q.pop_front());
        if (meas_valid === 1'b1 && ms_q.size() > 0)
            chk({high_cnt, per_cnt}, ms_q.pop_front());
        if (cyc == 60000) begin
            fails++;
            complete_run();
        end
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        int k;
        int per;
        int duty;
        int mult;
        int len;
        seed = 32'h90EA3670;
        repeat (4) @(posedge core_clk);
        sys_rst <= 1'b0;
        for (k = 0; k < 12; k++) rd(8'(k * 4), 8'h00);
        chk(32'(pwm_out), 32'h00000000);
        for (k = 0; k < 11; k++) begin
            wr(8'(k * 4), 8'hFF);
            rd(8'(k * 4), (k == 2) ? 8'h7F : (k == 8) ? 8'h3F : 8'hFF);
        end
        wr(OFS_U1_DUTY_SHAD, 8'h5A);
        rd(OFS_U1_DUTY_SHAD, 8'hFF);
        be_r <= 4'hE;
        wr(OFS_TB_PERIOD, 8'h11);
        be_r <= 4'hF;
        rd(OFS_TB_PERIOD, 8'hFF);
        wr(8'h2C, 8'h77);
        rd(8'h2C, 8'h00);
        for (k = 0; k < 11; k++) wr(8'(k * 4), 8'h00);
        // Every prescale and PWM mode code, nonzero postscale too
        for (k = 0; k < 4; k++) begin
            per  = $random(seed) & 32'hF;
            duty = 1 + int'($unsigned($random(seed)) % ((per + 1) * 4 - 1));
            mult = (k == 0) ? 1 : (k == 1) ? 4 : 16;
            // period, duty, prescale and run, then PWM mode
            wr(OFS_TB_PERIOD, 8'(per));
            wr(OFS_U1_DUTY_LOW, 8'(duty >> 2));
            wr(OFS_TB_CONTROL, {1'b0, 4'(k * 5), 1'b1, 2'(k)});
            wr(OFS_TB_COUNT, 8'h00);
            wr(OFS_U1_CONTROL, {2'b00, 2'(duty), 2'b11, 2'(k)});
            meas(duty * mult, (per + 1) * 4 * mult);
        end
        len = (per + 1) * 64;
        wr(OFS_U1_DUTY_LOW, 8'h00);
        wr(OFS_U1_CONTROL, 8'h0C);
        sample(len, 0);
        wr(OFS_U1_DUTY_LOW, 8'hFF);
        wr(OFS_U1_CONTROL, 8'h3C);
        wr(OFS_U2_DUTY_LOW, 8'hFF);
        wr(OFS_U2_CONTROL, 8'h3C);
        sample(len, len);
        chk(32'(pwm_out[1]), 32'h00000001);
        wr(OFS_U1_DUTY_SHAD, 8'h5A);
        rd(OFS_U1_DUTY_SHAD, 8'hFF);
        wr(OFS_U1_CONTROL, 8'h00);
        sample(len, 0);
        wr(OFS_TB_CONTROL, 8'h04);
        ev_cnt((per + 1) * 32, 8);
        wr(OFS_TB_CONTROL, 8'h0C);
        ev_cnt((per + 1) * 32, 4);
        wait (rd_q.size() == 0);
        complete_run();
    end
endmodule // tb_timer_based_pwm_output
